// ### los_mask_pkg.sv
// Constants for the loss-of-signal mask timing register bank
package los_mask_pkg;

  // ----------------------------------------------------------------
  // Register offsets
  // ----------------------------------------------------------------
  localparam logic [7:0] FALL_MASK_OFFSET   = 8'h0C;
  localparam logic [7:0] RISE_MASK_OFFSET   = 8'h0D;
  localparam logic [7:0] LEVEL_STAT_OFFSET  = 8'h0F;

  // ----------------------------------------------------------------
  // Field layout and reset values
  // ----------------------------------------------------------------
  localparam int         MASK_ENABLE_BIT    = 7;
  localparam int         MASK_TIME_MSB      = 5;
  localparam int         MASK_TIME_W        = 6;
  localparam int         LEVEL_W            = 7;
  localparam logic [7:0] MASK_CTRL_RESET    = 8'h00;
  localparam logic [7:0] UNMAPPED_READ      = 8'h00;

  // ----------------------------------------------------------------
  // Timing: interval = base + code * step
  // ----------------------------------------------------------------
  localparam int         CLK_PERIOD_NS      = 20;
  localparam int         MASK_BASE_NS       = 5000;   // Code 0, under 10 us
  localparam int         MASK_STEP_NS       = 32000;  // Code 63 gives 2.021 ms
  localparam int         MASK_BASE_CYCLES   = MASK_BASE_NS / CLK_PERIOD_NS;
  localparam int         MASK_STEP_CYCLES   = MASK_STEP_NS / CLK_PERIOD_NS;
  localparam int         MASK_CNT_W         = 17;
  localparam int         MIN_LIMIT_CYCLES   = 10000 / CLK_PERIOD_NS;
  localparam int         MAX_LIMIT_CYCLES   = 2000000 / CLK_PERIOD_NS;

endpackage : los_mask_pkg

// ### los_mask_timing_control.sv
// Loss-of-signal mask timing registers and output mask logic
`timescale 1ns/1ps
`default_nettype none

module los_mask_timing_control #(
  parameter int unsigned         BASE_CYCLES   = los_mask_pkg::MASK_BASE_CYCLES,
  parameter int unsigned         STEP_CYCLES   = los_mask_pkg::MASK_STEP_CYCLES,
  parameter logic [6:0]          DEFAULT_LEVEL = 7'h10  // Code of the 25 mV default level
) (
  // Clock and reset
  input  wire logic              SYS_CLK_IN,
  input  wire logic              SYS_RST_IN,
  // Register access from the two-wire interface control logic
  input  wire logic [7:0]        REG_ADDR_IN,
  input  wire logic              REG_WR_IN,
  input  wire logic [7:0]        REG_WDATA_IN,
  output logic      [7:0]        REG_RDATA_OUT,
  // Assert-level setting from the level register
  input  wire logic              ASSERT_LEVEL_SELECT_IN,
  input  wire logic [6:0]        ASSERT_LEVEL_CODE_IN,
  output logic      [6:0]        ACTIVE_ASSERT_LEVEL_OUT,
  // Detector and masked output
  input  wire logic              LOS_RAW_IN,
  output logic                   LOS_OUT
);

  // ----------------------------------------------------------------
  // Declarations
  // ----------------------------------------------------------------
  localparam int CW = los_mask_pkg::MASK_CNT_W;

  logic [7:0]    fall_ctrl_r;
  logic [7:0]    rise_ctrl_r;
  logic [CW-1:0] count_r;
  logic [CW-1:0] load_val;
  logic [5:0]    sel_code;
  logic          fall_edge;
  logic          rise_edge;
  logic          fall_en;
  logic          rise_en;
  logic          idle;
  logic [6:0]    active_level;

  // ----------------------------------------------------------------
  // Control registers
  // ----------------------------------------------------------------

  // Software writes to the two mask registers; status offset ignores writes
  always_ff @(posedge SYS_CLK_IN) begin
    if (SYS_RST_IN) begin
      fall_ctrl_r <= los_mask_pkg::MASK_CTRL_RESET;
      rise_ctrl_r <= los_mask_pkg::MASK_CTRL_RESET;
    end else if (REG_WR_IN) begin
      if (REG_ADDR_IN == los_mask_pkg::FALL_MASK_OFFSET) begin
        fall_ctrl_r <= REG_WDATA_IN;
      end
      if (REG_ADDR_IN == los_mask_pkg::RISE_MASK_OFFSET) begin
        rise_ctrl_r <= REG_WDATA_IN;
      end
    end
  end

  // Assert level in effect: programmed code or built-in default
  assign active_level = ASSERT_LEVEL_SELECT_IN ? ASSERT_LEVEL_CODE_IN : DEFAULT_LEVEL;
  assign ACTIVE_ASSERT_LEVEL_OUT = active_level;

  // Registered read data; unmapped offsets read zero
  always_ff @(posedge SYS_CLK_IN) begin
    if (SYS_RST_IN) begin
      REG_RDATA_OUT <= los_mask_pkg::UNMAPPED_READ;
    end else begin
      unique case (REG_ADDR_IN)
        los_mask_pkg::FALL_MASK_OFFSET:  REG_RDATA_OUT <= fall_ctrl_r;
        los_mask_pkg::RISE_MASK_OFFSET:  REG_RDATA_OUT <= rise_ctrl_r;
        los_mask_pkg::LEVEL_STAT_OFFSET: REG_RDATA_OUT <= {1'b0, active_level};
        default:                         REG_RDATA_OUT <= los_mask_pkg::UNMAPPED_READ;
      endcase
    end
  end

  // ----------------------------------------------------------------
  // Mask timing
  // ----------------------------------------------------------------

  // Edge detection against the current output, and interval length
  assign idle      = (count_r == '0);
  assign fall_edge = idle && LOS_OUT && !LOS_RAW_IN;
  assign rise_edge = idle && !LOS_OUT && LOS_RAW_IN;
  assign fall_en   = fall_ctrl_r[los_mask_pkg::MASK_ENABLE_BIT];
  assign rise_en   = rise_ctrl_r[los_mask_pkg::MASK_ENABLE_BIT];
  assign sel_code  = fall_edge ? fall_ctrl_r[los_mask_pkg::MASK_TIME_MSB:0]
                               : rise_ctrl_r[los_mask_pkg::MASK_TIME_MSB:0];
  // Linear in the code, so monotonic from code 0 to code 63
  assign load_val  = CW'(BASE_CYCLES - 32'd1 + 32'(sel_code) * STEP_CYCLES);

  // Output follows the detector while idle; an enabled edge starts a hold
  always_ff @(posedge SYS_CLK_IN) begin
    if (SYS_RST_IN) begin
      LOS_OUT <= 1'b0;
    end else if (idle) begin
      LOS_OUT <= LOS_RAW_IN;
    end
  end

  // Mask counter: loaded on an enabled edge, counts down to idle
  always_ff @(posedge SYS_CLK_IN) begin
    if (SYS_RST_IN) begin
      count_r <= '0;
    end else if (!idle) begin
      count_r <= count_r - CW'(1);
    end else if ((fall_edge && fall_en) || (rise_edge && rise_en)) begin
      count_r <= load_val;
    end
  end

  // ----------------------------------------------------------------
  // Assertions
  // ----------------------------------------------------------------
  default clocking cb @(posedge SYS_CLK_IN); endclocking
  default disable iff (SYS_RST_IN);

  // Output holds and the counter walks down while a mask runs
  a_mask_hold_out: assert property (!idle |=> $stable(LOS_OUT))
    else $error("Output moved during mask interval");
  a_count_steps_down: assert property (!idle |=> count_r == $past(count_r) - CW'(1))
    else $error("Mask counter did not step down");
  // Last count hands control back to the detector
  a_mask_ends: assert property (count_r == CW'(1)
      |=> idle)
    else $error("Mask counter did not return to idle");

  // Enabled edges start a mask; disabled edges pass straight through
  a_fall_mask_start: assert property (fall_edge && fall_en |=>
      !LOS_OUT && count_r == CW'(BASE_CYCLES - 1 + $past(fall_ctrl_r[5:0]) * STEP_CYCLES))
    else $error("Enabled falling edge did not start its mask");
  a_fall_nomask_pass: assert property (fall_edge && !fall_en |=> !LOS_OUT && idle)
    else $error("Falling edge masked while disabled");
  a_rise_mask_start: assert property (rise_edge && rise_en |=>
      LOS_OUT && count_r == CW'(BASE_CYCLES - 1 + $past(rise_ctrl_r[5:0]) * STEP_CYCLES))
    else $error("Enabled rising edge did not start its mask");
  a_rise_nomask_pass: assert property (rise_edge && !rise_en |=> LOS_OUT && idle)
    else $error("Rising edge masked while disabled");
  // Interval length limits for the extreme codes
  a_min_interval_short: assert property ((fall_edge && fall_en && fall_ctrl_r[5:0] == 6'h00)
      |=> count_r < CW'(los_mask_pkg::MIN_LIMIT_CYCLES))
    else $error("Shortest mask not below the limit");
  // Absolute time limit only holds with the real step size; scaled-down runs skip it
  if (STEP_CYCLES == los_mask_pkg::MASK_STEP_CYCLES) begin : g_real_timing
    a_max_interval_long: assert property ((rise_edge && rise_en && rise_ctrl_r[5:0] == 6'h3F)
        |=> count_r >= CW'(los_mask_pkg::MAX_LIMIT_CYCLES))
      else $error("Longest mask not above the limit");
  end
  // Loaded interval never exceeds the all-ones code length
  a_count_bounded: assert property (count_r <= CW'(BASE_CYCLES - 1 + 63 * STEP_CYCLES))
    else $error("Mask counter above the longest interval");

  // ----------------------------------------------------------------
  // Register checks
  // ----------------------------------------------------------------

  // Status read shows the level in effect
  a_status_read_level: assert property (REG_ADDR_IN == los_mask_pkg::LEVEL_STAT_OFFSET
      |=> REG_RDATA_OUT == {1'b0, $past(active_level)})
    else $error("Status read does not show active level");
  // Top bit of the status byte is always zero
  a_status_bit7_zero: assert property (REG_ADDR_IN == los_mask_pkg::LEVEL_STAT_OFFSET
      |=> !REG_RDATA_OUT[7])
    else $error("Status top bit not zero");
  // Default level chosen while select is low
  a_default_level_used: assert property (!ASSERT_LEVEL_SELECT_IN |-> ACTIVE_ASSERT_LEVEL_OUT == DEFAULT_LEVEL)
    else $error("Default level not used when select is low");

  // Writes land in the addressed mask register
  a_fall_reg_write: assert property (REG_WR_IN && REG_ADDR_IN == los_mask_pkg::FALL_MASK_OFFSET
      |=> fall_ctrl_r == $past(REG_WDATA_IN))
    else $error("Falling-mask register write lost");
  a_rise_reg_write: assert property (REG_WR_IN && REG_ADDR_IN == los_mask_pkg::RISE_MASK_OFFSET
      |=> rise_ctrl_r == $past(REG_WDATA_IN))
    else $error("Rising-mask register write lost");
  // Writes to the status offset leave both mask registers alone
  a_status_write_ignored: assert property (REG_WR_IN && REG_ADDR_IN == los_mask_pkg::LEVEL_STAT_OFFSET
      |=> $stable(fall_ctrl_r) && $stable(rise_ctrl_r))
    else $error("Status write changed a mask register");

  // Mask registers read back one cycle after the address
  a_fall_read_back: assert property (REG_ADDR_IN == los_mask_pkg::FALL_MASK_OFFSET
      |=> REG_RDATA_OUT == $past(fall_ctrl_r))
    else $error("Falling-mask read back wrong");
  a_rise_read_back: assert property (REG_ADDR_IN == los_mask_pkg::RISE_MASK_OFFSET
      |=> REG_RDATA_OUT == $past(rise_ctrl_r))
    else $error("Rising-mask read back wrong");
  // Unmapped offsets read zero
  a_unmapped_read_zero: assert property (REG_ADDR_IN != los_mask_pkg::FALL_MASK_OFFSET
      && REG_ADDR_IN != los_mask_pkg::RISE_MASK_OFFSET && REG_ADDR_IN != los_mask_pkg::LEVEL_STAT_OFFSET
      |=> REG_RDATA_OUT == los_mask_pkg::UNMAPPED_READ)
    else $error("Unmapped offset did not read zero");

  // Output follows the detector whenever no mask runs
  a_idle_follows_raw: assert property (idle |=> LOS_OUT == $past(LOS_RAW_IN))
    else $error("Output did not follow detector while idle");

  // ----------------------------------------------------------------
  // Coverage
  // ----------------------------------------------------------------

  // Main scenarios: both masks, ignored glitches, status access
  c_fall_masked: cover property (fall_edge && fall_en ##1 !idle [*3]);
  c_rise_masked: cover property (rise_edge && rise_en ##1 !idle);
  c_edge_ignored: cover property (!idle && LOS_RAW_IN != LOS_OUT);
  c_status_write: cover property (REG_WR_IN && REG_ADDR_IN == los_mask_pkg::LEVEL_STAT_OFFSET);
  c_default_level_read: cover property (!ASSERT_LEVEL_SELECT_IN && REG_ADDR_IN == los_mask_pkg::LEVEL_STAT_OFFSET);

endmodule : los_mask_timing_control

`default_nettype wire

// ### los_host_model.sv
// Host controller model driving the register port
`timescale 1ns/1ps
`default_nettype none
module los_host_model (
  // Clock and read data
  input  wire logic       clk_in,
  input  wire logic [7:0] rdata_in,
  // Register port drive and read strobe
  output var logic  [7:0] addr_out,
  output var logic        wr_out,
  output var logic  [7:0] wdata_out,
  output var logic        seen_stb_out
);
  // Idle bus at time zero
  initial begin
    addr_out = 8'h00;
    wr_out = 1'b0;
    wdata_out = 8'h00;
    seen_stb_out = 1'b0;
  end
  // One-cycle write strobe; data scrambled once taken
  task automatic wr(input logic [7:0] a, input logic [7:0] d);
    @(negedge clk_in);
    addr_out = a;
    wdata_out = d;
    wr_out = 1'b1;
    @(negedge clk_in);
    wr_out = 1'b0;
    wdata_out = ~d;
  endtask : wr
  // Read data is registered, so flag it one edge after the address
  task automatic rd(input logic [7:0] a);
    @(negedge clk_in);
    addr_out = a;
    @(negedge clk_in);
    seen_stb_out = 1'b1;
    @(negedge clk_in);
    seen_stb_out = 1'b0;
  endtask : rd
endmodule : los_host_model
`default_nettype wire

// ### tb_los_mask_timing_control.sv
// Self-checking bench for the loss-of-signal mask register bank
`timescale 1ns/1ps
`default_nettype none
module tb_los_mask_timing_control;
  localparam int         BASE = 3;
  localparam int         STEP = 2;
  localparam logic [6:0] DEF  = 7'h15;
  logic       clk = 1'b0, rst = 1'b1, sel = 1'b0, raw = 1'b0, stb, wr, los;
  logic [6:0] code = 7'h00, lvl;
  logic [7:0] addr, wdata, rdata, res, v;
  logic [7:0] exp_q[$];
  int         bad_count = 0, tests_run = 0, cyc = 0, n;
  event       res_ev;
  always #10 clk = ~clk;
  los_mask_timing_control #(.BASE_CYCLES(BASE), .STEP_CYCLES(STEP), .DEFAULT_LEVEL(DEF)) i_dut (
    .SYS_CLK_IN(clk), .SYS_RST_IN(rst), .REG_ADDR_IN(addr), .REG_WR_IN(wr), .REG_WDATA_IN(wdata),
    .REG_RDATA_OUT(rdata), .ASSERT_LEVEL_SELECT_IN(sel), .ASSERT_LEVEL_CODE_IN(code),
    .ACTIVE_ASSERT_LEVEL_OUT(lvl), .LOS_RAW_IN(raw), .LOS_OUT(los));
  los_host_model i_host (.clk_in(clk), .rdata_in(rdata), .addr_out(addr), .wr_out(wr),
    .wdata_out(wdata), .seen_stb_out(stb));
  task automatic check(input logic [7:0] seen, input logic [7:0] want);
    tests_run++;
    if (seen !== want) begin
      bad_count++;
      $display("[FAIL] %0t ns: saw %h, expected %h", $time, seen, want);
    end
  endtask : check
  task automatic wrap_up();
    $display("Checks %0d, mismatches %0d", tests_run, bad_count);
    if (bad_count == 0 && tests_run > 0) $display("All tests passed");
    else $display("Some tests failed");
    $finish;
  endtask : wrap_up
  task automatic post(input logic [7:0] r);
    res = r;
    ->res_ev;
  endtask : post
  // Watcher pairs each result with the oldest expectation
  initial forever begin
    @(res_ev);
    check(res, exp_q.pop_front());
  end
  // Read results and hang guard
  always @(posedge clk) begin
    cyc++;
    if (stb) post(rdata);
    if (cyc == 20000) begin
      bad_count++;
      wrap_up();
    end
  end
  // Program one edge, glitch the detector, count how long the output holds
  task automatic los_run(input logic up, input logic en, input logic [5:0] c);
    v = {en, 1'($urandom), c};
    i_host.wr(up ? 8'h0D : 8'h0C, v);
    i_host.wr(up ? 8'h0C : 8'h0D, 8'h00);
    exp_q.push_back(v);
    i_host.rd(up ? 8'h0D : 8'h0C);
    raw = !up;
    repeat (140) @(negedge clk);
    raw = up;
    @(negedge clk);
    raw = !up;
    n = 0;
    while (los === up && n < 250) begin
      n++;
      @(negedge clk);
    end
    exp_q.push_back(en ? 8'(BASE + c * STEP) : 8'h01);
    post(8'(n));
  endtask : los_run
  // Main sequence
  initial begin
    void'($urandom(32'h2758));
    repeat (6) @(negedge clk);
    rst = 1'b0;
    for (int a = 12; a < 15; a++) begin
      exp_q.push_back(8'h00);
      i_host.rd(8'(a));
    end
    for (int s = 0; s < 2; s++) begin
      sel = s[0];
      code = 7'($urandom);
      i_host.wr(8'h0F, 8'hFF);
      exp_q.push_back({1'b0, s[0] ? code : DEF});
      i_host.rd(8'h0F);
      exp_q.push_back({1'b0, s[0] ? code : DEF});
      post({1'b0, lvl});
    end
    for (int k = 0; k < 12; k++) los_run(k[0], k[1], k[3] ? 6'($urandom) : (k[2] ? 6'h3F : 6'h00));
    @(negedge clk);
    wrap_up();
  end
endmodule : tb_los_mask_timing_control
`default_nettype wire
